/* File: include/icd_pkg.sv */
/*
 * Shared constants and types for the serial current-output controller:
 * bus addresses, register map, reset values and the per-channel drive record.
 * Assumes a two-wire serial bus master outside and analog current cells that
 * consume the drive records.
 */
package icd_pkg;

   // Bus address bytes (write form) picked by the two strap inputs
   localparam logic [7:0] ICD_ADDR_STRAP_00 = 8'h20;
   localparam logic [7:0] ICD_ADDR_STRAP_01 = 8'h60;
   localparam logic [7:0] ICD_ADDR_STRAP_10 = 8'hA0;
   localparam logic [7:0] ICD_ADDR_STRAP_11 = 8'hE0;

   // Register map: channel settings sit at consecutive addresses from here
   localparam logic [7:0] ICD_REG_CH_BASE = 8'hF8;
   localparam int ICD_MAX_CHANNELS = 4;

   // Setting layout: polarity in the top bit, magnitude below
   localparam int ICD_POLARITY_BIT = 7;
   localparam int ICD_MAG_WIDTH = 7;
   localparam logic [7:0] ICD_SETTING_RESET = 8'h00;
   localparam logic [7:0] ICD_UNMAPPED_READ = 8'h00;
   localparam logic [6:0] ICD_MAG_ZERO = 7'h00;
   localparam logic [6:0] ICD_MAG_FULL = 7'h7F;

   // Polarity encodings
   localparam logic ICD_POL_SINK = 1'b0;
   localparam logic ICD_POL_SOURCE = 1'b1;

   // Drive record handed to one analog current cell
   typedef struct packed {
      logic active;
      logic source;
      logic [ICD_MAG_WIDTH-1:0] magnitude;
   } icd_drive_t;

   localparam icd_drive_t ICD_DRIVE_OFF = '{active: 1'b0, source: 1'b0, magnitude: 7'h00};

   // Serial engine states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_REG,
      ST_DATA,
      ST_ACK,
      ST_READ,
      ST_RACK,
      ST_IGNORE
   } icd_state_t;

endpackage : icd_pkg

/* File: rtl/icd_current_ctrl.sv */
/*
 * Serial slave that programs up to four sink/source current outputs.
 * The link side runs on link_clk and oversamples the bus pins; settings live
 * there and are copied into the ref_clk domain by a toggle handshake.
 * Assumes link_clk is free running and much faster than the bus clock.
 */
`timescale 1ns/1ps
module icd_current_ctrl
   import icd_pkg::*;
#(
   parameter int NUM_CHANNELS = ICD_MAX_CHANNELS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_strap_low,
   input wire logic addr_strap_high,
   output icd_drive_t channel_0_current,
   output icd_drive_t channel_1_current,
   output icd_drive_t channel_2_current,
   output icd_drive_t channel_3_current
);

   // Link domain: pin synchronisers (scl, sda, strap low, strap high)
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [3:0] pin_s3;
   logic [3:0] pin_filt;
   logic [3:0] pin_prev;
   logic [3:0] next_pin_filt;

   always_comb begin
      next_pin_filt = pin_filt;
      // A change counts only once the second and third stage agree
      for (int i = 0; i < 4; i++) begin
         if (pin_s2[i] == pin_s3[i]) begin
            next_pin_filt[i] = pin_s3[i];
         end
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 4'hF;
         pin_s2 <= 4'hF;
         pin_s3 <= 4'hF;
         pin_filt <= 4'hF;
         pin_prev <= 4'hF;
      end else begin
         pin_s1 <= {addr_strap_high, addr_strap_low, sda_in, scl_in};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_filt <= next_pin_filt;
         pin_prev <= pin_filt;
      end
   end

   // Bus events from the filtered levels
   logic scl_f;
   logic sda_f;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   assign scl_f = pin_filt[0];
   assign sda_f = pin_filt[1];
   assign scl_rise = scl_f && !pin_prev[0];
   assign scl_fall = !scl_f && pin_prev[0];
   assign start_cond = scl_f && pin_prev[0] && !sda_f && pin_prev[1];
   assign stop_cond = scl_f && pin_prev[0] && sda_f && !pin_prev[1];

   // Own address from the straps
   logic [7:0] own_addr;
   always_comb begin
      case (pin_filt[3:2])
         2'b00: own_addr = ICD_ADDR_STRAP_00;
         2'b01: own_addr = ICD_ADDR_STRAP_01;
         2'b10: own_addr = ICD_ADDR_STRAP_10;
         default: own_addr = ICD_ADDR_STRAP_11;
      endcase
   end

   // Link domain: serial engine and setting registers
   icd_state_t state;
   icd_state_t after_ack;
   logic [2:0] bit_cnt;
   logic byte_done;
   logic [7:0] shift;
   logic [7:0] reg_ptr;
   logic [7:0] setting [NUM_CHANNELS];
   logic drive_low;
   logic wr_toggle;
   icd_state_t next_state;
   icd_state_t next_after_ack;
   logic [2:0] next_bit_cnt;
   logic next_byte_done;
   logic [7:0] next_shift;
   logic [7:0] next_reg_ptr;
   logic [7:0] next_setting [NUM_CHANNELS];
   logic next_drive_low;
   logic next_wr_toggle;

   // Register decode against the last pointer
   logic [7:0] ptr_off;
   logic ptr_valid;
   logic [7:0] rd_val;
   assign ptr_off = reg_ptr - ICD_REG_CH_BASE;
   assign ptr_valid = (reg_ptr >= ICD_REG_CH_BASE) &&
                      (ptr_off < 8'(NUM_CHANNELS));

   always_comb begin
      rd_val = ICD_UNMAPPED_READ;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         if (ptr_valid && ptr_off == 8'(i)) begin
            rd_val = setting[i];
         end
      end
   end

   always_comb begin
      next_state = state;
      next_after_ack = after_ack;
      next_bit_cnt = bit_cnt;
      next_byte_done = byte_done;
      next_shift = shift;
      next_reg_ptr = reg_ptr;
      next_setting = setting;
      next_drive_low = drive_low;
      next_wr_toggle = wr_toggle;
      if (start_cond) begin
         // Any start, repeated or not, restarts address reception
         next_state = ST_ADDR;
         next_bit_cnt = 3'd0;
         next_byte_done = 1'b0;
         next_drive_low = 1'b0;
      end else if (stop_cond) begin
         next_state = ST_IDLE;
         next_byte_done = 1'b0;
         next_drive_low = 1'b0;
      end else begin
         case (state)
            ST_ADDR, ST_REG, ST_DATA: begin
               if (scl_rise) begin
                  next_shift = {shift[6:0], sda_f};
                  next_bit_cnt = bit_cnt + 3'd1;
                  if (bit_cnt == 3'd7) begin
                     next_byte_done = 1'b1;
                  end
               end else if (scl_fall && byte_done) begin
                  // Acknowledge goes out after the falling edge of bit eight
                  next_byte_done = 1'b0;
                  next_state = ST_ACK;
                  next_drive_low = 1'b1;
                  next_after_ack = ST_DATA;
                  if (state == ST_ADDR) begin
                     if (shift[7:1] == own_addr[7:1]) begin
                        next_after_ack = shift[0] ? ST_READ : ST_REG;
                     end else begin
                        next_state = ST_IGNORE;
                        next_drive_low = 1'b0;
                     end
                  end else if (state == ST_REG) begin
                     next_reg_ptr = shift;
                  end else begin
                     for (int i = 0; i < NUM_CHANNELS; i++) begin
                        if (ptr_valid && ptr_off == 8'(i)) begin
                           next_setting[i] = shift;
                        end
                     end
                     if (ptr_valid) begin
                        next_wr_toggle = !wr_toggle;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  next_state = after_ack;
                  next_bit_cnt = 3'd0;
                  next_drive_low = 1'b0;
                  if (after_ack == ST_READ) begin
                     next_shift = rd_val;
                     next_drive_low = !rd_val[7];
                  end
               end
            end
            ST_READ: begin
               if (scl_rise) begin
                  next_bit_cnt = bit_cnt + 3'd1;
                  if (bit_cnt == 3'd7) begin
                     next_byte_done = 1'b1;
                  end
               end else if (scl_fall) begin
                  if (byte_done) begin
                     // Let go so the master can answer in the ninth bit
                     next_byte_done = 1'b0;
                     next_drive_low = 1'b0;
                     next_state = ST_RACK;
                  end else begin
                     next_shift = {shift[6:0], 1'b0};
                     next_drive_low = !shift[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  if (sda_f) begin
                     next_state = ST_IGNORE;
                  end else begin
                     next_byte_done = 1'b1;
                  end
               end else if (scl_fall && byte_done) begin
                  // Master wants more: resend the same register
                  next_byte_done = 1'b0;
                  next_shift = rd_val;
                  next_drive_low = !rd_val[7];
                  next_bit_cnt = 3'd0;
                  next_state = ST_READ;
               end
            end
            ST_IDLE, ST_IGNORE: begin
               next_drive_low = 1'b0;
            end
            default: begin
               next_state = ST_IDLE;
               next_drive_low = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         after_ack <= ST_IDLE;
         bit_cnt <= 3'd0;
         byte_done <= 1'b0;
         shift <= 8'h00;
         reg_ptr <= ICD_REG_CH_BASE;
         drive_low <= 1'b0;
         wr_toggle <= 1'b0;
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            setting[i] <= ICD_SETTING_RESET;
         end
      end else begin
         state <= next_state;
         after_ack <= next_after_ack;
         bit_cnt <= next_bit_cnt;
         byte_done <= next_byte_done;
         shift <= next_shift;
         reg_ptr <= next_reg_ptr;
         drive_low <= next_drive_low;
         wr_toggle <= next_wr_toggle;
         setting <= next_setting;
      end
   end

   // Open-drain data pin: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = drive_low;

   // Ref domain copy on a synchronised toggle; the next write is a whole bus byte away
   logic [2:0] tog_sync;
   logic tog_seen;
   logic [7:0] out_setting [NUM_CHANNELS];
   logic [2:0] next_tog_sync;
   logic next_tog_seen;
   logic [7:0] next_out_setting [NUM_CHANNELS];

   always_comb begin
      next_tog_sync = {tog_sync[1:0], wr_toggle};
      next_tog_seen = tog_seen;
      next_out_setting = out_setting;
      if (tog_sync[1] == tog_sync[2] && tog_sync[2] != tog_seen) begin
         next_tog_seen = tog_sync[2];
         next_out_setting = setting;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_sync <= 3'b000;
         tog_seen <= 1'b0;
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            out_setting[i] <= ICD_SETTING_RESET;
         end
      end else begin
         tog_sync <= next_tog_sync;
         tog_seen <= next_tog_seen;
         out_setting <= next_out_setting;
      end
   end

   // Drive records; missing channels of the small variant stay off
   icd_drive_t drive [ICD_MAX_CHANNELS];
   for (genvar g = 0; g < ICD_MAX_CHANNELS; g++) begin : gen_drive
      if (g < NUM_CHANNELS) begin : gen_on
         // Magnitude 0..127 maps linearly onto the full-scale current
         assign drive[g].active = out_setting[g][ICD_MAG_WIDTH-1:0] != ICD_MAG_ZERO;
         assign drive[g].source = out_setting[g][ICD_POLARITY_BIT];
         assign drive[g].magnitude = out_setting[g][ICD_MAG_WIDTH-1:0];
      end else begin : gen_off
         assign drive[g] = ICD_DRIVE_OFF;
      end
   end

   assign channel_0_current = drive[0];
   assign channel_1_current = drive[1];
   assign channel_2_current = drive[2];
   assign channel_3_current = drive[3];

endmodule : icd_current_ctrl

/* File: verification/icd_current_ctrl_monitor.sv */
/* Bus-side and channel-side checks for the current controller.
   Sees only the top ports; bound into every controller instance. */
`timescale 1ns/1ps
module icd_current_ctrl_monitor
   import icd_pkg::*;
#(
   parameter int NUM_CHANNELS = ICD_MAX_CHANNELS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic addr_strap_low,
   input wire logic addr_strap_high,
   input wire icd_drive_t channel_0_current,
   input wire icd_drive_t channel_1_current,
   input wire icd_drive_t channel_2_current,
   input wire icd_drive_t channel_3_current
);
   logic [8:0] oe_cnt;
   logic [8:0] next_oe_cnt;
   logic [5:0] hi_cnt;
   logic [5:0] next_hi_cnt;
   // Run lengths of a pulled data line and of a high clock line
   always_comb begin
      next_oe_cnt = sda_oe ? oe_cnt + 9'h001 : 9'h000;
      next_hi_cnt = !scl_in ? 6'h00 : (hi_cnt == 6'h3F) ? hi_cnt : hi_cnt + 6'h01;
   end
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_cnt <= 9'h000;
         hi_cnt <= 6'h00;
      end else begin
         oe_cnt <= next_oe_cnt;
         hi_cnt <= next_hi_cnt;
      end
   end
   a_chan0_zero_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      channel_0_current.active == (channel_0_current.magnitude != ICD_MAG_ZERO))
      else $error("channel 0 active flag disagrees with magnitude");
   a_chan3_zero_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      channel_3_current.active == (channel_3_current.magnitude != ICD_MAG_ZERO))
      else $error("channel 3 active flag disagrees with magnitude");
   a_chan_reset_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(rst_n) |-> {channel_0_current, channel_1_current, channel_2_current,
      channel_3_current} == 36'h0) else $error("channel output not cleared by reset");
   a_oe_reset_free: assert property (@(posedge link_clk) disable iff (!rst_n)
      $rose(rst_n) |-> !sda_oe ##1 !sda_oe) else $error("data pulled after reset");
   a_oe_scl_low: assert property (@(posedge link_clk) disable iff (!rst_n)
      !$stable(sda_oe) |-> !scl_in) else $error("data drive changed with clock high");
   a_oe_bounded: assert property (@(posedge link_clk) disable iff (!rst_n)
      oe_cnt < 9'h190) else $error("data line held low far too long");
   a_idle_released: assert property (@(posedge link_clk) disable iff (!rst_n)
      hi_cnt > 6'h28 |-> !sda_oe [*2]) else $error("data pulled on an idle bus");
   a_open_drain: assert property (@(posedge link_clk) disable iff (!rst_n)
      sda_out == 1'b0) else $error("data output drives high");
   a_small_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      NUM_CHANNELS > 2 || {channel_2_current, channel_3_current} == 18'h0)
      else $error("missing channel of the small variant is driven");
endmodule : icd_current_ctrl_monitor

bind icd_current_ctrl icd_current_ctrl_monitor #(.NUM_CHANNELS(NUM_CHANNELS)) u_monitor (
   .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_low(addr_strap_low),
   .addr_strap_high(addr_strap_high), .channel_0_current(channel_0_current),
   .channel_1_current(channel_1_current), .channel_2_current(channel_2_current),
   .channel_3_current(channel_3_current));

/* File: verification/icd_bus_master.sv */
/* Behavioural two-wire bus master driven from ref_clk edges.
   Assumes a pull-up resolves the data wire outside. */
`timescale 1ns/1ps
module icd_bus_master (
   input wire logic ref_clk,
   input wire logic sda,
   output logic scl,
   output logic oe
);
   // Idle bus: clock high, data released
   initial begin
      scl = 1'b1;
      oe = 1'b0;
   end
   // Quarter bit; two of them per clock phase keep well clear of the pin filter
   task automatic q;
      repeat (5) @(posedge ref_clk);
   endtask : q
   // Start, also used as repeated start
   task automatic start;
      oe <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      oe <= 1'b1;
      q();
      scl <= 1'b0;
      q();
   endtask : start
   task automatic stop;
      oe <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      oe <= 1'b0;
      q();
      q();
   endtask : stop
   // Data moves only while the clock is low
   task automatic put(input logic b);
      oe <= !b;
      q();
      scl <= 1'b1;
      q();
      q();
      scl <= 1'b0;
      q();
   endtask : put
   task automatic get(output logic b);
      oe <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      b = sda;
      q();
      scl <= 1'b0;
      q();
   endtask : get
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put(d[i]);
      get(b);
      ack = !b;
   endtask : wbyte
   task automatic rbyte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get(d[i]);
      put(last);
   endtask : rbyte
endmodule : icd_bus_master

/* File: verification/icd_current_ctrl_tb_top.sv */
/* Self-checking bench for the current controller with a bus master model.
   Assumes the design package is compiled first. */
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module icd_current_ctrl_tb_top;
   import icd_pkg::*;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic strap_lo = 1'b0;
   logic strap_hi = 1'b0;
   logic scl_w;
   logic m_oe;
   logic sda_out;
   logic sda_oe;
   wire logic sda_w;
   icd_drive_t ch[4];
   icd_drive_t ch_small[4];
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [7:0] tab[4] = '{8'h20, 8'h60, 8'hA0, 8'hE0};
   logic [7:0] val[4] = '{8'hAA, 8'h80, 8'h7F, 8'h01};
   // Pull-up wire: low whenever either party pulls
   assign sda_w = !(m_oe || (sda_oe && !sda_out));
   always #50 ref_clk = ~ref_clk;
   always #32 link_clk = ~link_clk;
   icd_bus_master m (.ref_clk(ref_clk), .sda(sda_w), .scl(scl_w), .oe(m_oe));
   icd_current_ctrl #(.NUM_CHANNELS(4)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_w), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_low(strap_lo), .addr_strap_high(strap_hi),
      .channel_0_current(ch[0]), .channel_1_current(ch[1]), .channel_2_current(ch[2]),
      .channel_3_current(ch[3]));
   // Two-channel variant listens on the same bus; its data drive stays off the wire
   icd_current_ctrl #(.NUM_CHANNELS(2)) dut_small (
      .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_w), .sda_in(sda_w),
      .sda_out(), .sda_oe(), .addr_strap_low(1'b0), .addr_strap_high(1'b0),
      .channel_0_current(ch_small[0]), .channel_1_current(ch_small[1]),
      .channel_2_current(ch_small[2]), .channel_3_current(ch_small[3]));
   function automatic icd_drive_t drv(input logic [7:0] v);
      return {|v[6:0], v[7], v[6:0]};
   endfunction : drv
   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      logic k;
      logic [7:0] b[3];
      b = '{8'h20, r, d};
      m.start();
      for (int i = 0; i < 3; i++) begin
         m.wbyte(b[i], k);
         `CHK(k, 1'b1)
      end
      m.stop();
   endtask : wr
   // Optional pointer write, then a repeated start and a one-byte read
   task automatic rd(input logic p, input logic [7:0] r, output logic [7:0] d);
      logic k;
      if (p) begin
         m.start();
         m.wbyte(8'h20, k);
         m.wbyte(r, k);
      end
      m.start();
      m.wbyte(8'h21, k);
      `CHK(k, 1'b1)
      m.rbyte(1'b1, d);
      m.stop();
   endtask : rd
   task automatic t_reset;
      logic [7:0] d;
      for (int i = 0; i < 4; i++) `CHK(ch[i], ICD_DRIVE_OFF)
      rd(1'b0, 8'h00, d);
      `CHK(d, 8'h00)
      $display("test reset done");
   endtask : t_reset
   // Every strap setting against every address; a stray byte after a miss
   task automatic t_addr;
      logic k;
      for (int s = 0; s < 4; s++) begin
         strap_hi <= s[1];
         strap_lo <= s[0];
         repeat (10) @(posedge ref_clk);
         for (int a = 0; a < 4; a++) begin
            m.start();
            m.wbyte(tab[a], k);
            `CHK(k, a == s)
            if (a != s) begin
               m.wbyte(tab[s], k);
               `CHK(k, 1'b0)
            end
            m.stop();
         end
      end
      strap_hi <= 1'b0;
      strap_lo <= 1'b0;
      repeat (10) @(posedge ref_clk);
      $display("test address done");
   endtask : t_addr
   task automatic t_rw;
      logic [7:0] d;
      for (int i = 0; i < 4; i++) wr(8'hF8 + 8'(i), val[i]);
      repeat (10) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         `CHK(ch[i], drv(val[i]))
         `CHK(ch_small[i], (i < 2) ? drv(val[i]) : ICD_DRIVE_OFF)
         rd(1'b1, 8'hF8 + 8'(i), d);
         `CHK(d, val[i])
      end
      $display("test write read done");
   endtask : t_rw
   // Writes on either side of the map must leave every channel alone
   task automatic t_unmapped;
      logic [7:0] d;
      logic [7:0] r[2];
      r = '{8'hF7, 8'hFC};
      for (int i = 0; i < 2; i++) begin
         wr(r[i], 8'h55);
         rd(1'b1, r[i], d);
         `CHK(d, 8'h00)
      end
      for (int i = 0; i < 4; i++) `CHK(ch[i], drv(val[i]))
      $display("test unmapped done");
   endtask : t_unmapped
   // Reset in mid-run with live settings drops every channel back to zero current
   task automatic t_rst_mid;
      logic [7:0] d;
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         `CHK(ch[i], ICD_DRIVE_OFF)
         `CHK(ch_small[i], ICD_DRIVE_OFF)
      end
      rst_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rd(1'b1, 8'hFA, d);
      `CHK(d, 8'h00)
      $display("test mid reset done");
   endtask : t_rst_mid
   task automatic test_done;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done
   // Whole run needs about 15000 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      t_reset();
      t_addr();
      t_rw();
      t_unmapped();
      t_rst_mid();
      test_done();
   end
endmodule : icd_current_ctrl_tb_top
